// ### core/csuc_pkg.sv
// Constants, field layout and command codes of the current-sense and user configuration words.
// Assumes one core clock, a synchronous active-low reset and a command port fed by the bus logic.
// Functional notes
// RULE1: Fault-count codes 001..111 mean 3..15 events.
// RULE2: Fault only after selected consecutive qualifying events.
// RULE3: At most one event counted per switching cycle.
// RULE4: Bits 3:2 choose the current-sensing method.
// RULE5: Bits 1:0 choose the sense input range.
// RULE6: Minimum duty is (2*field+2)/512.
// RULE7: Clamp minimum duty only while bit 7 set.
// RULE8: Bit 5 chooses which setpoint strap pin counts.
// RULE9: Disabled low-side drive level follows bit 3.
// RULE10: Bit 2 chooses open-drain or push-pull power-good.
// RULE11: Bit 1 enables the external temperature sensor.
// RULE12: Bit 0 makes external sensor the fault source.
// RULE13: User word loads from strap after reset.
// RULE14: Separate readable writable user word per page.
// RULE15: Host stores user word right after writing; csuc_host_model only writes and reads, no store command exists.
// RULE16: Fault-count code 000 needs one event.
// RULE17: Eventless switching cycle clears the counter.
// RULE18: Unused bits read zero and ignore writes.
package csuc_pkg;

  // ---------------------------------------------------------------
  // Sizes and command codes
  // ---------------------------------------------------------------
  localparam int          NUM_PAGES      = 2;
  localparam int          CNT_W          = 4;
  localparam logic [7:0]  CMD_CS_CFG     = 8'hD0;
  localparam logic [7:0]  CMD_USER_CFG   = 8'hD1;

  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam logic [15:0] CS_WR_MASK     = 16'h070F;
  localparam logic [15:0] USER_WR_MASK   = 16'hF8AF;
  localparam int          CS_CNT_LSB     = 8;
  localparam int          CS_METHOD_LSB  = 2;
  localparam int          CS_RANGE_LSB   = 0;
  localparam int          UC_MIN_LSB     = 11;
  localparam int          UC_MIN_EN_BIT  = 7;
  localparam int          UC_VSEL_BIT    = 5;
  localparam int          UC_LSD_BIT     = 3;
  localparam int          UC_PG_PP_BIT   = 2;
  localparam int          UC_XT_EN_BIT   = 1;
  localparam int          UC_XT_FLT_BIT  = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CS_RESET       = 16'h0000;
  localparam logic [15:0] USER_RESET     = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CSUC_SENSE_NONE = 2'b00,
    CSUC_SENSE_DOWN = 2'b01,
    CSUC_SENSE_UP   = 2'b10,
    CSUC_SENSE_PSM  = 2'b11
  } csuc_method_t;

  typedef enum logic [1:0] {
    CSUC_RANGE_LOW  = 2'b00,
    CSUC_RANGE_MED  = 2'b01,
    CSUC_RANGE_HIGH = 2'b10,
    CSUC_RANGE_NONE = 2'b11
  } csuc_range_t;

endpackage : csuc_pkg

// ### core/csuc_qual_if.sv
// Carrier between the register bank and one fault qualifier.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface csuc_qual_if;
  logic                     cycle_end;
  logic                     event_hit;
  logic [2:0]               count_code;
  logic                     fault;
  logic [csuc_pkg::CNT_W-1:0] consec_cnt;

  modport bank (output cycle_end, output event_hit, output count_code,
                input fault, input consec_cnt);
  modport qual (input cycle_end, input event_hit, input count_code,
                output fault, output consec_cnt);
endinterface : csuc_qual_if

// ### core/csuc_fault_qual.sv
// Consecutive overcurrent or undercurrent event qualifier for one output.
// Assumes event and cycle-end strobes come from logic on the core clock.
`timescale 1ns/1ps
module csuc_fault_qual
  import csuc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  csuc_qual_if.qual q
);

  typedef struct packed {
    logic             seen;
    logic [CNT_W-1:0] cnt;
    logic             fault;
  } csuc_qual_st_t;

  csuc_qual_st_t s_q;
  csuc_qual_st_t s_d;
  logic [CNT_W-1:0] need;
  logic             hit;

  always_comb begin
    s_d  = s_q;
    need = {q.count_code, 1'b1};                     // [RULE1] [RULE16]
    hit  = s_q.seen | q.event_hit;
    if (q.cycle_end) begin
      s_d.seen = 1'b0;                               // [RULE3]
      if (hit) begin
        if (s_q.cnt < need) begin
          s_d.cnt = s_q.cnt + 4'h1;                  // [RULE3]
        end
        s_d.fault = (s_d.cnt >= need);               // [RULE2]
      end else begin
        s_d.cnt   = CNT_RESET;                       // [RULE17]
        s_d.fault = 1'b0;
      end
    end else if (q.event_hit) begin
      s_d.seen = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q.fault      = s_q.fault;
  assign q.consec_cnt = s_q.cnt;

endmodule : csuc_fault_qual

// ### core/csuc_top.sv
// Paged current-sense and user configuration words and the logic they steer.
// Assumes a command port decoded from the bus and strobes on the core clock.
`timescale 1ns/1ps
module csuc_top
  import csuc_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       cmd_wr,
  input  wire logic                       cmd_rd,
  input  wire logic [0:0]                 cmd_page,
  input  wire logic [7:0]                 cmd_code,
  input  wire logic [15:0]                cmd_wdata,
  output logic      [15:0]                rd_data,
  output logic                            rd_valid,
  input  wire logic [15:0]                cfg_strap_word,
  input  wire logic [NUM_PAGES-1:0]       sw_cycle_end,
  input  wire logic [NUM_PAGES-1:0]       overcurrent_event,
  input  wire logic [NUM_PAGES-1:0]       undercurrent_event,
  output logic      [NUM_PAGES-1:0]       current_fault,
  output logic      [2*NUM_PAGES-1:0]     sense_method,
  output logic      [2*NUM_PAGES-1:0]     sense_range,
  input  wire logic [9*NUM_PAGES-1:0]     duty_cmd,
  output logic      [9*NUM_PAGES-1:0]     duty_out,
  input  wire logic [NUM_PAGES-1:0]       setpoint_strap_pin_a,
  input  wire logic [NUM_PAGES-1:0]       setpoint_strap_pin_b,
  output logic      [NUM_PAGES-1:0]       setpoint_strap_sel,
  input  wire logic [NUM_PAGES-1:0]       output_enabled,
  input  wire logic [NUM_PAGES-1:0]       pwm_low_in,
  output logic      [NUM_PAGES-1:0]       low_side_drive_output,
  input  wire logic [NUM_PAGES-1:0]       power_good_status,
  output logic      [NUM_PAGES-1:0]       power_good_output_o,
  output logic      [NUM_PAGES-1:0]       power_good_output_oe,
  output logic      [NUM_PAGES-1:0]       external_temp_sensor_en,
  input  wire logic [NUM_PAGES-1:0]       ext_temp_fault_in,
  input  wire logic [NUM_PAGES-1:0]       int_temp_fault_in,
  output logic      [NUM_PAGES-1:0]       temp_fault
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PAGES-1:0][15:0] user_w;
    logic [NUM_PAGES-1:0][15:0] cs_w;
    logic                       init_done;
    logic [15:0]                rdata;
    logic                       rvalid;
    logic [15:0]                strap_s1;
    logic [15:0]                strap_s2;
    logic [NUM_PAGES-1:0]       pin_a_s1;
    logic [NUM_PAGES-1:0]       pin_a_s2;
    logic [NUM_PAGES-1:0]       pin_b_s1;
    logic [NUM_PAGES-1:0]       pin_b_s2;
  } csuc_top_st_t;

  csuc_top_st_t s_q;
  csuc_top_st_t s_d;

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.strap_s1 = cfg_strap_word;
    s_d.strap_s2 = s_q.strap_s1;
    s_d.pin_a_s1 = setpoint_strap_pin_a;
    s_d.pin_a_s2 = s_q.pin_a_s1;
    s_d.pin_b_s1 = setpoint_strap_pin_b;
    s_d.pin_b_s2 = s_q.pin_b_s1;
    s_d.rvalid   = 1'b0;
    if (!s_q.init_done) begin
      s_d.init_done = 1'b1;
      for (int p = 0; p < NUM_PAGES; p++) begin
        s_d.user_w[p] = s_q.strap_s2 & USER_WR_MASK;          // [RULE13] [RULE18]
      end
    end else if (cmd_wr) begin
      if (cmd_code == CMD_USER_CFG) begin
        s_d.user_w[cmd_page] = cmd_wdata & USER_WR_MASK;      // [RULE14] [RULE18]
      end else if (cmd_code == CMD_CS_CFG) begin
        s_d.cs_w[cmd_page] = cmd_wdata & CS_WR_MASK;          // [RULE18]
      end
    end
    if (cmd_rd) begin
      s_d.rvalid = 1'b1;
      if (cmd_code == CMD_USER_CFG) begin
        s_d.rdata = s_q.user_w[cmd_page];                     // [RULE14]
      end else if (cmd_code == CMD_CS_CFG) begin
        s_d.rdata = s_q.cs_w[cmd_page];
      end else begin
        s_d.rdata = 16'h0000;
      end
    end
    // Synchronisers keep running in reset so the strap value is ready at release.
    if (!rst_n) begin
      s_d          = '0;
      s_d.strap_s1 = cfg_strap_word;
      s_d.strap_s2 = s_q.strap_s1;
      s_d.pin_a_s1 = setpoint_strap_pin_a;
      s_d.pin_a_s2 = s_q.pin_a_s1;
      s_d.pin_b_s1 = setpoint_strap_pin_b;
      s_d.pin_b_s2 = s_q.pin_b_s1;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign rd_data  = s_q.rdata;
  assign rd_valid = s_q.rvalid;

  // ---------------------------------------------------------------
  // Per-page datapath
  // ---------------------------------------------------------------
  for (genvar p = 0; p < NUM_PAGES; p++) begin : g_page
    csuc_qual_if qif ();
    logic [15:0] uw;
    logic [15:0] cw;
    logic [8:0]  min_duty;
    logic [8:0]  dc;

    assign uw             = s_q.user_w[p];
    assign cw             = s_q.cs_w[p];
    assign qif.cycle_end  = sw_cycle_end[p];
    assign qif.event_hit  = overcurrent_event[p] | undercurrent_event[p];
    assign qif.count_code = cw[CS_CNT_LSB +: 3];                        // [RULE1]

    csuc_fault_qual u_qual (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .q        (qif.qual)
    );

    assign current_fault[p]        = qif.fault;                         // [RULE2]
    assign sense_method[2*p +: 2]  = cw[CS_METHOD_LSB +: 2];            // [RULE4]
    assign sense_range[2*p +: 2]   = cw[CS_RANGE_LSB +: 2];             // [RULE5]

    assign min_duty = {3'h0, uw[UC_MIN_LSB +: 5], 1'b0} + 9'h002;       // [RULE6]
    assign dc       = duty_cmd[9*p +: 9];
    assign duty_out[9*p +: 9] =
      (uw[UC_MIN_EN_BIT] && (dc < min_duty)) ? min_duty : dc;           // [RULE7]

    assign setpoint_strap_sel[p] =
      uw[UC_VSEL_BIT] ? s_q.pin_b_s2[p] : s_q.pin_a_s2[p];              // [RULE8]

    assign low_side_drive_output[p] =
      output_enabled[p] ? pwm_low_in[p] : uw[UC_LSD_BIT];               // [RULE9]

    assign power_good_output_o[p]  =
      uw[UC_PG_PP_BIT] ? power_good_status[p] : 1'b0;                   // [RULE10]
    assign power_good_output_oe[p] =
      uw[UC_PG_PP_BIT] ? 1'b1 : ~power_good_status[p];                  // [RULE10]

    assign external_temp_sensor_en[p] = uw[UC_XT_EN_BIT];               // [RULE11]
    assign temp_fault[p] =
      uw[UC_XT_FLT_BIT] ? ext_temp_fault_in[p] : int_temp_fault_in[p];  // [RULE12]
  end

endmodule : csuc_top

// ### verif/csuc_host_model.sv
// Bus host model that issues write and read commands on the command port.
// Assumes the core clock and drives every request just after a falling edge.
`timescale 1ns/1ps
module csuc_host_model (
  input  wire logic        core_clk,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [0:0]       cmd_page,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  initial {cmd_wr, cmd_rd, cmd_page, cmd_code, cmd_wdata} = '0;
  task automatic wr(input logic [0:0] p, input logic [7:0] c, input logic [15:0] d);
    @(negedge core_clk);
    {cmd_wr, cmd_page, cmd_code, cmd_wdata} = {1'b1, p, c, d};
    @(negedge core_clk);
    cmd_wr    = 1'b0;
    cmd_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [0:0] p, input logic [7:0] c, output logic [15:0] d,
                    output logic v);
    @(negedge core_clk);
    {cmd_rd, cmd_page, cmd_code} = {1'b1, p, c};
    @(negedge core_clk);
    cmd_rd = 1'b0;
    d      = rd_data;
    v      = rd_valid;
  endtask : rd
endmodule : csuc_host_model

// ### verif/csuc_top_props.sv
// Port-level checker of the configuration top.
// Assumes a bind onto csuc_top and a single core clock domain.
`timescale 1ns/1ps
module csuc_top_props
  import csuc_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 cmd_rd,
  input wire logic [15:0]          rd_data,
  input wire logic                 rd_valid,
  input wire logic [NUM_PAGES-1:0] sw_cycle_end,
  input wire logic [NUM_PAGES-1:0] current_fault,
  input wire logic [17:0]          duty_cmd,
  input wire logic [17:0]          duty_out,
  input wire logic [NUM_PAGES-1:0] setpoint_strap_pin_a,
  input wire logic [NUM_PAGES-1:0] setpoint_strap_pin_b,
  input wire logic [NUM_PAGES-1:0] setpoint_strap_sel,
  input wire logic [NUM_PAGES-1:0] output_enabled,
  input wire logic [NUM_PAGES-1:0] pwm_low_in,
  input wire logic [NUM_PAGES-1:0] low_side_drive_output,
  input wire logic [NUM_PAGES-1:0] power_good_status,
  input wire logic [NUM_PAGES-1:0] power_good_output_o,
  input wire logic [NUM_PAGES-1:0] power_good_output_oe,
  input wire logic [NUM_PAGES-1:0] ext_temp_fault_in,
  input wire logic [NUM_PAGES-1:0] int_temp_fault_in,
  input wire logic [NUM_PAGES-1:0] temp_fault
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_read_answer: assert property (cmd_rd |=> rd_valid)
    else $error("read not answered next cycle");
  chk_read_data_holds: assert property ($past(rst_n) && !$past(cmd_rd)
    |-> $stable(rd_data))
    else $error("read data moved without a read");
  chk_fault_at_end: assert property ($past(rst_n) && $changed(current_fault[0])
    |-> $past(sw_cycle_end[0]))
    else $error("fault moved outside a cycle end");
  chk_low_side_follow: assert property (
    (output_enabled & (low_side_drive_output ^ pwm_low_in)) == '0)
    else $error("enabled low-side drive differs from pwm");
  chk_pg_drive_style: assert property (
    (power_good_output_oe & (power_good_output_o ^ power_good_status)) == '0
    && (~power_good_output_oe & ~power_good_status) == '0)
    else $error("power-good drive wrong");
  chk_duty_floor: assert property (duty_out[8:0] == duty_cmd[8:0]
    || (duty_out[8:0] > duty_cmd[8:0] && !duty_out[0]))
    else $error("duty clamp value wrong");
  chk_strap_pick: assert property ($past(rst_n) && $past(rst_n, 2) |->
    setpoint_strap_sel[0] == $past(setpoint_strap_pin_a[0], 2)
    || setpoint_strap_sel[0] == $past(setpoint_strap_pin_b[0], 2))
    else $error("strap select matches neither pin");
  chk_temp_source: assert property (ext_temp_fault_in == int_temp_fault_in
    |-> temp_fault == ext_temp_fault_in)
    else $error("temperature fault from no source");
endmodule : csuc_top_props
bind csuc_top csuc_top_props chk_u (.*);

// ### verif/tb_top.sv
// Self-checking bench of the configuration top with a reference model.
// Assumes the host model and the bound checker; inputs change at falling edges.
`timescale 1ns/1ps
module tb_top
  import csuc_pkg::*;
();
  logic        core_clk = 1'b0, rst_n = 1'b0, cmd_wr, cmd_rd, rd_valid, vld;
  logic [0:0]  cmd_page;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rd_data, cfg_strap_word, w, got, ucfg [2];
  logic [1:0]  sw_cycle_end, overcurrent_event, undercurrent_event, current_fault;
  logic [1:0]  setpoint_strap_pin_a, setpoint_strap_pin_b, setpoint_strap_sel, pwm_low_in;
  logic [1:0]  output_enabled, low_side_drive_output, power_good_status, power_good_output_o;
  logic [1:0]  power_good_output_oe, external_temp_sensor_en, ext_temp_fault_in;
  logic [1:0]  int_temp_fault_in, temp_fault;
  logic [3:0]  sense_method, sense_range;
  logic [17:0] duty_cmd, duty_out;
  integer      seed = 75319, fail_count = 0, cmp_count = 0, cnt, n;
  always #25 core_clk = ~core_clk;
  csuc_host_model host_u (.*);
  csuc_top dut_u (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rdchk(input int p, input logic [7:0] c, input logic [15:0] e);
    host_u.rd(p[0], c, got, vld);
    chk(vld, 1);
    chk(got, e);
  endtask : rdchk
  task automatic rnd_pins();
    {duty_cmd, setpoint_strap_pin_a, setpoint_strap_pin_b, pwm_low_in} = 24'($random(seed));
    {output_enabled, power_good_status, ext_temp_fault_in, int_temp_fault_in} = 8'($random(seed));
  endtask : rnd_pins
  task automatic feat();
    logic [8:0] mn;
    logic [8:0] dc;
    logic [1:0] pg;
    logic       sp;
    for (int p = 0; p < 2; p++) begin
      mn = 9'(2 * ucfg[p][15:11] + 2);
      dc = duty_cmd[9*p +: 9];
      pg = ucfg[p][2] ? {power_good_status[p], 1'b1} : {1'b0, ~power_good_status[p]};
      chk(duty_out[9*p +: 9], (ucfg[p][7] && dc < mn) ? mn : dc);
      sp = ucfg[p][5] ? setpoint_strap_pin_b[p] : setpoint_strap_pin_a[p];
      chk(setpoint_strap_sel[p], sp);
      chk(low_side_drive_output[p], output_enabled[p] ? pwm_low_in[p] : ucfg[p][3]);
      chk({power_good_output_o[p], power_good_output_oe[p]}, pg);
      chk(external_temp_sensor_en[p], ucfg[p][1]);
      chk(temp_fault[p], ucfg[p][0] ? ext_temp_fault_in[p] : int_temp_fault_in[p]);
    end
  endtask : feat
  task automatic swc(input logic ev);
    @(negedge core_clk);
    {overcurrent_event, undercurrent_event} = ev ? (($random(seed) & 1) ? 4'hC : 4'h3) : 4'h0;
    @(negedge core_clk);
    @(negedge core_clk);
    {overcurrent_event, undercurrent_event, sw_cycle_end} = 6'h03;
    @(negedge core_clk);
    sw_cycle_end = 2'b00;
  endtask : swc
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    summarize();
  end
  initial begin
    cfg_strap_word = 16'($random(seed));
    {sw_cycle_end, overcurrent_event, undercurrent_event} = '0;
    rnd_pins();
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    for (int p = 0; p < 2; p++) begin
      ucfg[p] = cfg_strap_word & USER_WR_MASK;
      rdchk(p, CMD_USER_CFG, ucfg[p]);
    end
    $display("strap load test done");
    for (int i = 0; i < 8; i++) begin
      w = 16'($random(seed));
      n = i % 2;
      host_u.wr(n[0], CMD_USER_CFG, w);
      ucfg[n] = w & USER_WR_MASK;
      w = {w[15:4], 2'(i >> 1), 2'(3 - (i >> 1))};
      host_u.wr(n[0], CMD_CS_CFG, w);
      rdchk(n, CMD_USER_CFG, ucfg[n]);
      rdchk(n, CMD_CS_CFG, w & CS_WR_MASK);
      rdchk(1 - n, CMD_USER_CFG, ucfg[1-n]);
      chk(sense_method[2*n +: 2], w[3:2]);
      chk(sense_range[2*n +: 2], w[1:0]);
      rnd_pins();
      repeat (3) @(negedge core_clk);
      feat();
    end
    rdchk(0, 8'hD5, 16'h0000);
    $display("register and feature test done");
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 2; p++) host_u.wr(p[0], CMD_CS_CFG, 16'(c << 8));
      swc(1'b0);
      cnt = 0;
      n = 2 * c + 1;
      for (int k = 0; k <= n; k++) begin
        swc(1'b1);
        cnt++;
        chk(current_fault, {2{cnt >= n}});
      end
      swc(1'b0);
      chk(current_fault, 2'b00);
    end
    $display("fault count test done");
    summarize();
  end
endmodule : tb_top
